/* common/eft_pkg.sv */
package eft_pkg;

  // Register offsets in the paged register file.
  localparam logic [7:0] OFS_CAP_ONE_HIGH = 8'hF0;
  localparam logic [7:0] OFS_CAP_ONE_LOW  = 8'hF1;
  localparam logic [7:0] OFS_CAP_TWO_HIGH = 8'hF2;
  localparam logic [7:0] OFS_CAP_TWO_LOW  = 8'hF3;
  localparam logic [7:0] OFS_CNT_HIGH     = 8'hF4;
  localparam logic [7:0] OFS_CNT_LOW      = 8'hF5;
  localparam logic [7:0] OFS_ALT_HIGH     = 8'hF6;
  localparam logic [7:0] OFS_ALT_LOW      = 8'hF7;
  localparam logic [7:0] OFS_CMP_ONE_HIGH = 8'hF8;
  localparam logic [7:0] OFS_CMP_ONE_LOW  = 8'hF9;
  localparam logic [7:0] OFS_CMP_TWO_HIGH = 8'hFA;
  localparam logic [7:0] OFS_CMP_TWO_LOW  = 8'hFB;
  localparam logic [7:0] OFS_CONTROL_ONE  = 8'hFC;
  localparam logic [7:0] OFS_CONTROL_TWO  = 8'hFD;
  localparam logic [7:0] OFS_TIMER_FLAGS  = 8'hFE;
  localparam logic [7:0] OFS_CONTROL_THREE = 8'hFF;

  // Reset values and the counter maximum.
  localparam logic [15:0] CNT_RESET_VALUE = 16'hFFFC;
  localparam logic [15:0] CNT_MAX_VALUE   = 16'hFFFF;
  localparam logic [7:0]  CMP_HIGH_RESET  = 8'h80;
  localparam logic [7:0]  CMP_LOW_RESET   = 8'h00;
  localparam logic [7:0]  CONTROL_RESET   = 8'h00;

  // Control one bit positions.
  localparam int CAPTURE_IRQ_ENABLE_BIT  = 7;
  localparam int COMPARE_IRQ_ENABLE_BIT  = 6;
  localparam int OVERFLOW_IRQ_ENABLE_BIT = 5;
  localparam int EDGE_ONE_BIT            = 1;

  // Control two bit positions.
  localparam int CLOCK_SEL_LSB = 2;
  localparam int EDGE_TWO_BIT  = 1;
  localparam int EXT_EDGE_BIT  = 0;

  // Control three bit positions.
  localparam int OVERFLOW_SEL_BIT  = 3;
  localparam int COMPARE_SEL_BIT   = 2;
  localparam int CAPTURE_SEL_BIT   = 1;
  localparam int GLOBAL_IRQ_SEL_BIT = 0;
  localparam logic [7:0] CONTROL_THREE_MASK = 8'h0F;

  // Flag vector indices; the status byte is the flag vector above three zero bits.
  localparam int FLAG_COUNT   = 5;
  localparam int FLAG_CMP_TWO = 0;
  localparam int FLAG_CAP_TWO = 1;
  localparam int FLAG_OVF     = 2;
  localparam int FLAG_CMP_ONE = 3;
  localparam int FLAG_CAP_ONE = 4;

  // Prescaler divisions.
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT  = 2'h3;

endpackage

/* common/eft_flags_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface eft_flags_if;
  logic [4:0] setEvent;
  logic [4:0] lowAccess;
  logic       statusAccess;
  logic [4:0] flags;

  modport timer (output setEvent, output lowAccess, output statusAccess, input flags);
  modport unit  (input setEvent, input lowAccess, input statusAccess, output flags);
endinterface
`default_nettype wire

/* rtl/eft_flag_unit.sv */
`timescale 1ns/1ns
`default_nettype none
module eft_flag_unit
  import eft_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Flag handshake.
  eft_flags_if.unit fl
);

  logic [FLAG_COUNT-1:0] armed;
  logic [FLAG_COUNT-1:0] flagReg;

  assign fl.flags = flagReg;

  genvar i;
  generate
    for (i = 0; i < FLAG_COUNT; i++) begin : gFlag
      // A status access arms only flags already set; a later low-byte access clears armed ones.
      always_ff @(posedge clk) begin
        if (srst) begin
          armed[i] <= 1'b0;
        end else if (fl.statusAccess) begin
          armed[i] <= flagReg[i];
        end else if (fl.lowAccess[i]) begin
          armed[i] <= 1'b0;
        end
      end

      // A new event wins over a clear in the same cycle.
      always_ff @(posedge clk) begin
        if (srst) begin
          flagReg[i] <= 1'b0;
        end else if (fl.setEvent[i]) begin
          flagReg[i] <= 1'b1;
        end else if (fl.lowAccess[i] && armed[i]) begin
          flagReg[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule // eft_flag_unit
`default_nettype wire

/* rtl/eft_timer.sv */
// Behaviour
// - One capture enable covers both captures; pin two's selected edge always captures.
// - A flag clears after a status access then its matching low-byte access.
// - Three controls, one status and six 16-bit pairs split into bytes.
// - Each capture event copies the counter into that capture's read-only pair.
// - Counter resets to FFFC; high read-only, low writable; alternate pair mirrors it.
// - Writing either counter low byte resets the free-running counter.
// - Counter low access after a status access clears the overflow flag.
// - Alternate counter low access never clears the overflow flag.
// - Compares are writable pairs, reset 8000, matched against the counter.
// - Status holds five flags in bits 7 to 3; bits 2 to 0 read zero.
// - Overflow flag sets when the counter rolls from FFFF to zero.
// - Control three bit 0 picks the global timer interrupt when set.
`timescale 1ns/1ns
`default_nettype none
module eft_timer
  import eft_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       srst,
  // Register file port.
  input  wire logic [7:0] regAddr,
  input  wire logic       regRead,
  input  wire logic       regWrite,
  input  wire logic [7:0] regWdata,
  output var  logic [7:0] regRdata,
  output var  logic       regRdataValid,
  // Pins.
  input  wire logic       capturePinOne,
  input  wire logic       capturePinTwo,
  input  wire logic       extClockPin,
  // Interrupt requests.
  output var  logic       globalIrq,
  output var  logic       captureIrq,
  output var  logic       compareIrq,
  output var  logic       overflowIrq,
  // Timer state to waveform logic.
  output var  logic [15:0] counterValue,
  output var  logic       compareOneMatch,
  output var  logic       compareTwoMatch
);

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs, input logic acc);
    hit = acc && (addr == ofs);
  endfunction

  eft_flags_if fl ();

  eft_flag_unit uFlags (
    .clk  (clk),
    .srst (srst),
    .fl   (fl.unit)
  );

  logic        access;
  logic [7:0]  controlOne;
  logic [7:0]  controlTwo;
  logic [7:0]  controlThree;
  logic [15:0] counter;
  logic [15:0] captureOne;
  logic [15:0] captureTwo;
  logic [15:0] compareOne;
  logic [15:0] compareTwo;
  logic [1:0]  compareLive;
  logic        counterMoved;
  logic [2:0]  capOneSync;
  logic [2:0]  capTwoSync;
  logic [2:0]  extSync;
  logic        capOneEvent;
  logic        capTwoEvent;
  logic        extEvent;
  logic [2:0]  prescale;
  logic        tick;
  logic        counterReset;
  logic        overflowEvent;
  logic [1:0]  compareHit;
  logic [4:0]  enabledFlags;
  logic [7:0]  next_rdata;

  assign access = regRead || regWrite;

  // Control registers.
  always_ff @(posedge clk) begin
    if (srst) begin
      controlOne   <= CONTROL_RESET;
      controlTwo   <= CONTROL_RESET;
      controlThree <= CONTROL_RESET;
    end else begin
      if (hit(regAddr, OFS_CONTROL_ONE, regWrite)) begin
        controlOne <= regWdata;
      end
      if (hit(regAddr, OFS_CONTROL_TWO, regWrite)) begin
        controlTwo <= regWdata;
      end
      if (hit(regAddr, OFS_CONTROL_THREE, regWrite)) begin
        controlThree <= regWdata & CONTROL_THREE_MASK;
      end
    end
  end

  // Pin synchronisers; the third stage only feeds edge detection.
  always_ff @(posedge clk) begin
    if (srst) begin
      capOneSync <= 3'h0;
      capTwoSync <= 3'h0;
      extSync    <= 3'h0;
    end else begin
      capOneSync <= {capOneSync[1:0], capturePinOne};
      capTwoSync <= {capTwoSync[1:0], capturePinTwo};
      extSync    <= {extSync[1:0], extClockPin};
    end
  end

  assign capOneEvent = controlOne[EDGE_ONE_BIT] ? (capOneSync[1] && !capOneSync[2])
                                                : (!capOneSync[1] && capOneSync[2]);
  // Pin two captures on its edge whatever the pin is used for elsewhere.
  assign capTwoEvent = controlTwo[EDGE_TWO_BIT] ? (capTwoSync[1] && !capTwoSync[2])
                                                : (!capTwoSync[1] && capTwoSync[2]);
  assign extEvent    = controlTwo[EXT_EDGE_BIT] ? (extSync[1] && !extSync[2])
                                                : (!extSync[1] && extSync[2]);

  // Prescaler producing one counter tick every 2, 4 or 8 clocks, or one per external clock edge.
  always_ff @(posedge clk) begin
    if (srst) begin
      prescale <= 3'h0;
    end else begin
      prescale <= prescale + 3'h1;
    end
  end

  always_comb begin
    case (controlTwo[CLOCK_SEL_LSB +: 2])
      CLK_DIV4: tick = (prescale[1:0] == 2'h3);
      CLK_DIV2: tick = prescale[0];
      CLK_DIV8: tick = (prescale == 3'h7);
      CLK_EXT:  tick = extEvent;
      default:  tick = 1'b0;
    endcase
  end

  // Free-running counter.
  assign counterReset = hit(regAddr, OFS_CNT_LOW, regWrite) || hit(regAddr, OFS_ALT_LOW, regWrite);
  assign overflowEvent = tick && !counterReset && (counter == CNT_MAX_VALUE);

  always_ff @(posedge clk) begin
    if (srst) begin
      counter      <= CNT_RESET_VALUE;
      counterMoved <= 1'b0;
    end else if (counterReset) begin
      counter      <= CNT_RESET_VALUE;
      counterMoved <= 1'b1;
    end else begin
      counter      <= tick ? counter + 16'h0001 : counter;
      counterMoved <= tick;
    end
  end

  // Input captures copy the counter.
  always_ff @(posedge clk) begin
    if (capOneEvent) begin
      captureOne <= counter;
    end
    if (capTwoEvent) begin
      captureTwo <= counter;
    end
  end

  // Compare registers; writing a high byte holds off matching until the low byte is written.
  always_ff @(posedge clk) begin
    if (srst) begin
      compareOne  <= {CMP_HIGH_RESET, CMP_LOW_RESET};
      compareTwo  <= {CMP_HIGH_RESET, CMP_LOW_RESET};
      compareLive <= 2'h3;
    end else begin
      if (hit(regAddr, OFS_CMP_ONE_HIGH, regWrite)) begin
        compareOne[15:8] <= regWdata;
        compareLive[0]   <= 1'b0;
      end
      if (hit(regAddr, OFS_CMP_ONE_LOW, regWrite)) begin
        compareOne[7:0] <= regWdata;
        compareLive[0]  <= 1'b1;
      end
      if (hit(regAddr, OFS_CMP_TWO_HIGH, regWrite)) begin
        compareTwo[15:8] <= regWdata;
        compareLive[1]   <= 1'b0;
      end
      if (hit(regAddr, OFS_CMP_TWO_LOW, regWrite)) begin
        compareTwo[7:0] <= regWdata;
        compareLive[1]  <= 1'b1;
      end
    end
  end

  assign compareHit[0] = counterMoved && compareLive[0] && (counter == compareOne);
  assign compareHit[1] = counterMoved && compareLive[1] && (counter == compareTwo);

  always_ff @(posedge clk) begin
    if (srst) begin
      compareOneMatch <= 1'b0;
      compareTwoMatch <= 1'b0;
      counterValue    <= CNT_RESET_VALUE;
    end else begin
      compareOneMatch <= compareHit[0];
      compareTwoMatch <= compareHit[1];
      counterValue    <= counter;
    end
  end

  // Flag events and two-step clearing.
  assign fl.setEvent[FLAG_CAP_ONE] = capOneEvent;
  assign fl.setEvent[FLAG_CMP_ONE] = compareHit[0];
  assign fl.setEvent[FLAG_OVF]     = overflowEvent;
  assign fl.setEvent[FLAG_CAP_TWO] = capTwoEvent;
  assign fl.setEvent[FLAG_CMP_TWO] = compareHit[1];
  assign fl.statusAccess = hit(regAddr, OFS_TIMER_FLAGS, access);
  assign fl.lowAccess[FLAG_CAP_ONE] = hit(regAddr, OFS_CAP_ONE_LOW, access);
  assign fl.lowAccess[FLAG_CMP_ONE] = hit(regAddr, OFS_CMP_ONE_LOW, access);
  // Only the main counter low byte clears overflow; the alternate one is left out.
  assign fl.lowAccess[FLAG_OVF]     = hit(regAddr, OFS_CNT_LOW, access);
  assign fl.lowAccess[FLAG_CAP_TWO] = hit(regAddr, OFS_CAP_TWO_LOW, access);
  assign fl.lowAccess[FLAG_CMP_TWO] = hit(regAddr, OFS_CMP_TWO_LOW, access);

  // Interrupt routing.
  always_comb begin
    enabledFlags = 5'h00;
    enabledFlags[FLAG_CAP_ONE] = fl.flags[FLAG_CAP_ONE] && controlOne[CAPTURE_IRQ_ENABLE_BIT];
    enabledFlags[FLAG_CAP_TWO] = fl.flags[FLAG_CAP_TWO] && controlOne[CAPTURE_IRQ_ENABLE_BIT];
    enabledFlags[FLAG_CMP_ONE] = fl.flags[FLAG_CMP_ONE] && controlOne[COMPARE_IRQ_ENABLE_BIT];
    enabledFlags[FLAG_CMP_TWO] = fl.flags[FLAG_CMP_TWO] && controlOne[COMPARE_IRQ_ENABLE_BIT];
    enabledFlags[FLAG_OVF]     = fl.flags[FLAG_OVF] && controlOne[OVERFLOW_IRQ_ENABLE_BIT];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      globalIrq   <= 1'b0;
      captureIrq  <= 1'b0;
      compareIrq  <= 1'b0;
      overflowIrq <= 1'b0;
    end else if (controlThree[GLOBAL_IRQ_SEL_BIT]) begin
      globalIrq   <= |enabledFlags;
      captureIrq  <= 1'b0;
      compareIrq  <= 1'b0;
      overflowIrq <= 1'b0;
    end else begin
      globalIrq   <= 1'b0;
      captureIrq  <= controlThree[CAPTURE_SEL_BIT] &&
                     (enabledFlags[FLAG_CAP_ONE] || enabledFlags[FLAG_CAP_TWO]);
      compareIrq  <= controlThree[COMPARE_SEL_BIT] &&
                     (enabledFlags[FLAG_CMP_ONE] || enabledFlags[FLAG_CMP_TWO]);
      overflowIrq <= controlThree[OVERFLOW_SEL_BIT] && enabledFlags[FLAG_OVF];
    end
  end

  // Read multiplexer over the byte-wide register map.
  always_comb begin
    case (regAddr)
      OFS_CAP_ONE_HIGH:  next_rdata = captureOne[15:8];
      OFS_CAP_ONE_LOW:   next_rdata = captureOne[7:0];
      OFS_CAP_TWO_HIGH:  next_rdata = captureTwo[15:8];
      OFS_CAP_TWO_LOW:   next_rdata = captureTwo[7:0];
      OFS_CNT_HIGH:      next_rdata = counter[15:8];
      OFS_CNT_LOW:       next_rdata = counter[7:0];
      OFS_ALT_HIGH:      next_rdata = counter[15:8];
      OFS_ALT_LOW:       next_rdata = counter[7:0];
      OFS_CMP_ONE_HIGH:  next_rdata = compareOne[15:8];
      OFS_CMP_ONE_LOW:   next_rdata = compareOne[7:0];
      OFS_CMP_TWO_HIGH:  next_rdata = compareTwo[15:8];
      OFS_CMP_TWO_LOW:   next_rdata = compareTwo[7:0];
      OFS_CONTROL_ONE:   next_rdata = controlOne;
      OFS_CONTROL_TWO:   next_rdata = controlTwo;
      OFS_TIMER_FLAGS:   next_rdata = {fl.flags, 3'h0};
      OFS_CONTROL_THREE: next_rdata = controlThree;
      default:           next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      regRdata      <= 8'h00;
      regRdataValid <= 1'b0;
    end else begin
      regRdata      <= regRead ? next_rdata : 8'h00;
      regRdataValid <= regRead;
    end
  end

endmodule // eft_timer
`default_nettype wire

/* testbench/eft_timer_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module eft_timer_chk
  import eft_pkg::*;
(
  // Clock and reset.
  input wire logic        clk,
  input wire logic        srst,
  // Register file port.
  input wire logic [7:0]  regAddr,
  input wire logic        regRead,
  input wire logic        regWrite,
  input wire logic [7:0]  regWdata,
  input wire logic [7:0]  regRdata,
  input wire logic        regRdataValid,
  // Pins and requests.
  input wire logic        capturePinTwo,
  input wire logic        globalIrq,
  input wire logic        captureIrq,
  input wire logic        compareIrq,
  input wire logic        overflowIrq,
  // Timer state.
  input wire logic [15:0] counterValue,
  input wire logic        compareOneMatch
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [7:0] ctlOne;
  logic [7:0] ctlThree;
  // Shadows of control one and control three as software wrote them.
  always_ff @(posedge clk) begin
    if (srst) ctlOne <= 8'h00;
    else if (regWrite && regAddr == OFS_CONTROL_ONE) ctlOne <= regWdata;
  end
  always_ff @(posedge clk) begin
    if (srst) ctlThree <= 8'h00;
    else if (regWrite && regAddr == OFS_CONTROL_THREE) ctlThree <= regWdata;
  end
  property p_rvalid; regRead |=> regRdataValid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_noread; !regRead |=> !regRdataValid && regRdata == 8'h00; endproperty
  a_noread: assert property (p_noread) else $error("read data without read");
  property p_status; regRead && regAddr == OFS_TIMER_FLAGS |=> regRdata[2:0] == 3'b000; endproperty
  a_status: assert property (p_status) else $error("status low bits not zero");
  property p_unmapped; regRead && regAddr < 8'hF0 |=> regRdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_global_off;
    !ctlThree[0] && !$past(ctlThree[0]) && !$past(ctlThree[0], 2) |-> !globalIrq;
  endproperty
  a_global_off: assert property (p_global_off) else $error("global request while deselected");
  property p_sep_off;
    ctlThree[0] && $past(ctlThree[0]) && $past(ctlThree[0], 2) |-> !(captureIrq || compareIrq || overflowIrq);
  endproperty
  a_sep_off: assert property (p_sep_off) else $error("separate request in global mode");
  property p_ovf;
    $past(counterValue) == 16'hFFFF && counterValue == 16'h0000 && ctlOne[5] && ctlThree[0] |-> ##[0:3] globalIrq;
  endproperty
  a_ovf: assert property (p_ovf) else $error("rollover raised no request");
  property p_cap; $fell(capturePinTwo) && ctlOne[7] && ctlThree[0] |-> ##[1:6] globalIrq; endproperty
  a_cap: assert property (p_cap) else $error("second capture raised no request");
  property p_reload;
    regWrite && (regAddr == OFS_CNT_LOW || regAddr == OFS_ALT_LOW) |=> ##1 counterValue[15:2] == 14'h3FFF;
  endproperty
  a_reload: assert property (p_reload) else $error("counter not reloaded");
  property p_match; compareOneMatch |=> !compareOneMatch; endproperty
  a_match: assert property (p_match) else $error("match pulse too long");
  c_ovf: cover property (globalIrq && ctlOne[5]);
  c_cap: cover property ($fell(capturePinTwo) && ctlOne[7]);
  c_match: cover property (compareOneMatch);
endmodule // eft_timer_chk
bind eft_timer eft_timer_chk chk (.clk(clk), .srst(srst), .regAddr(regAddr), .regRead(regRead),
  .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata), .regRdataValid(regRdataValid),
  .capturePinTwo(capturePinTwo), .globalIrq(globalIrq), .captureIrq(captureIrq), .compareIrq(compareIrq),
  .overflowIrq(overflowIrq), .counterValue(counterValue), .compareOneMatch(compareOneMatch));
`default_nettype wire

/* testbench/eft_timer_test.sv */
`timescale 1ns/1ns
`default_nettype none
module eft_timer_test
  import eft_pkg::*;
;
  logic        clk, srst, regRead, regWrite, regRdataValid, capturePinOne, capturePinTwo, extClockPin;
  logic [7:0]  regAddr, regWdata, regRdata;
  logic        globalIrq, captureIrq, compareIrq, overflowIrq, compareOneMatch, compareTwoMatch;
  logic [15:0] counterValue;
  int          bad_count = 0;
  int          n_tests = 0;
  int          cycles = 0;

  eft_timer uut (.clk(clk), .srst(srst), .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata(regRdata), .regRdataValid(regRdataValid), .capturePinOne(capturePinOne),
    .capturePinTwo(capturePinTwo), .extClockPin(extClockPin), .globalIrq(globalIrq), .captureIrq(captureIrq),
    .compareIrq(compareIrq), .overflowIrq(overflowIrq), .counterValue(counterValue),
    .compareOneMatch(compareOneMatch), .compareTwoMatch(compareTwoMatch));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One-cycle write strobe, then one idle cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    @(negedge clk);
  endtask

  // Read, compare the masked answer; a zero mask makes a plain access.
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    chk($sformatf("reg %h", a), regRdata & m, e);
    @(negedge clk);
  endtask

  // Waits for the global request (sel 0) or the second match pulse (sel 1).
  task automatic waitSig(input int sel, input int lim);
    for (int i = 0; i < lim; i++) begin
      if ((sel == 0 ? globalIrq : compareTwoMatch) === 1'b1) break;
      @(negedge clk);
    end
    chk("wait", {7'h00, (sel == 0 ? globalIrq : compareTwoMatch)}, 8'h01);
  endtask

  task automatic irqLow();
    repeat (2) @(negedge clk);
    chk("globalIrq", {7'h00, globalIrq}, 8'h00);
  endtask

  initial begin
    srst = 1'b1;
    regAddr = 8'h00;
    regWdata = 8'h00;
    regRead = 1'b0;
    regWrite = 1'b0;
    capturePinOne = 1'b1;
    capturePinTwo = 1'b1;
    extClockPin = 1'b0;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    rd(OFS_TIMER_FLAGS, 8'hFF, 8'h00);
    rd(OFS_CNT_HIGH, 8'hFF, 8'hFF);
    rd(OFS_ALT_HIGH, 8'hFF, 8'hFF);
    rd(OFS_ALT_LOW, 8'hFC, 8'hFC);
    for (int i = 0; i < 8; i++) begin
      if (i != 6) rd(8'hF8 + 8'(i), 8'hFF, (i < 4 && i % 2 == 0) ? 8'h80 : 8'h00);
    end
    wr(OFS_CONTROL_THREE, 8'hFF);
    rd(OFS_CONTROL_THREE, 8'hFF, 8'h0F);
    rd(8'h10, 8'hFF, 8'h00);
    for (int i = 0; i < 4; i++) wr(8'hF8 + 8'(i), 8'h11 * 8'(i + 1));
    for (int i = 0; i < 4; i++) rd(8'hF8 + 8'(i), 8'hFF, 8'h11 * 8'(i + 1));
    // The first rollover has already set overflow; arm it so the reload write clears it.
    rd(OFS_TIMER_FLAGS, 8'h00, 8'h00);
    wr(OFS_CONTROL_ONE, 8'h20);
    wr(OFS_CONTROL_THREE, 8'h01);
    wr(OFS_CNT_LOW, 8'h00);
    chk("counterValue", counterValue[15:8], 8'hFF);
    rd(OFS_TIMER_FLAGS, 8'hFF, 8'h00);
    waitSig(0, 40);
    rd(OFS_TIMER_FLAGS, 8'hFF, 8'h20);
    rd(OFS_ALT_LOW, 8'h00, 8'h00);
    rd(OFS_TIMER_FLAGS, 8'hFF, 8'h20);
    rd(OFS_CNT_LOW, 8'h00, 8'h00);
    rd(OFS_TIMER_FLAGS, 8'hFF, 8'h00);
    irqLow();
    wr(OFS_CONTROL_ONE, 8'h40);
    for (int i = 0; i < 4; i++) wr(8'hF8 + 8'(i), i == 1 ? 8'h10 : (i == 3 ? 8'h20 : 8'h00));
    wr(OFS_ALT_LOW, 8'h00);
    waitSig(0, 300);
    waitSig(1, 300);
    rd(OFS_TIMER_FLAGS, 8'hD8, 8'h48);
    rd(OFS_CMP_ONE_LOW, 8'h00, 8'h00);
    rd(OFS_TIMER_FLAGS, 8'hD8, 8'h08);
    rd(OFS_CMP_TWO_LOW, 8'h00, 8'h00);
    rd(OFS_TIMER_FLAGS, 8'hD8, 8'h00);
    irqLow();
    wr(OFS_CONTROL_ONE, 8'h80);
    rd(OFS_TIMER_FLAGS, 8'h00, 8'h00);
    capturePinOne = 1'b0;
    repeat (6) @(negedge clk);
    rd(OFS_CAP_ONE_LOW, 8'h00, 8'h00);
    rd(OFS_TIMER_FLAGS, 8'hD8, 8'h80);
    rd(OFS_CAP_ONE_LOW, 8'h00, 8'h00);
    rd(OFS_TIMER_FLAGS, 8'hD8, 8'h00);
    wr(OFS_CNT_LOW, 8'h00);
    capturePinTwo = 1'b0;
    waitSig(0, 10);
    rd(OFS_TIMER_FLAGS, 8'hD8, 8'h10);
    rd(OFS_CAP_TWO_HIGH, 8'hFF, 8'hFF);
    rd(OFS_CAP_TWO_LOW, 8'hFC, 8'hFC);
    rd(OFS_TIMER_FLAGS, 8'hD8, 8'h00);
    irqLow();
    // Separate request lines: a falling edge on pin two must raise only the capture request.
    wr(OFS_CONTROL_THREE, 8'h0E);
    capturePinTwo = 1'b1;
    repeat (4) @(negedge clk);
    capturePinTwo = 1'b0;
    repeat (6) @(negedge clk);
    chk("captureIrq", {7'h00, captureIrq}, 8'h01);
    chk("otherIrqs", {5'h00, globalIrq, compareIrq, overflowIrq}, 8'h00);
    conclude();
  end
endmodule // eft_timer_test
`default_nettype wire
